// *** dv/xd_ext_decoder_bench.sv ***
// testbench: self-checking random and corner runs of the extended decoder
`timescale 1ns/10ps
module xd_ext_decoder_bench;
  // ----
  // signals and model state
  // ----
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ext_en = 1'b0;
  logic [15:0] insn = 16'h0000;
  logic [20:0] pc_in = 21'h000000;
  logic [3:0] bank_sel = 4'h0;
  logic [20:0] stack_top = 21'h000000;
  logic [7:0] pc_hi = 8'h00;
  logic [4:0] pc_up = 5'h00;
  logic [11:0] rf_addr, rf_waddr;
  logic rf_rd, rf_we, pc_load, stack_push, stack_pop, second_cycle, illegal_ext;
  logic [7:0] rf_wdata, work_out;
  wire logic [7:0] rf_rdata;
  logic [11:0] ptr [3];
  logic [1:0] nz;
  logic [20:0] pc_target, push_data;
  logic [7:0] mem [4096];
  logic [11:0] mp [3] = '{12'h000, 12'h000, 12'h000};
  logic [7:0] mw = 8'h00;
  logic [1:0] mf;
  logic [3:0] vb;
  logic [20:0] vt, vpc;
  logic [7:0] vh;
  logic [4:0] vu;
  logic [11:0] s_wa;
  logic [7:0] s_wd;
  logic [20:0] s_pt, s_pd;
  int n_we, n_ld, n_push, n_pop, n_ill, n_sc, n_neg, s_ph;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;

  always #20 clock = ~clock;

  // register file answers in the same cycle
  assign rf_rdata = mem[rf_addr];

  xd_ext_decoder i_xd_ext_decoder (
    .clock(clock), .rst_n(rst_n), .extended_set_enable_bit(ext_en), .insn(insn),
    .pc_in(pc_in), .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_rdata(rf_rdata), .rf_we(rf_we),
    .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .bank_select_register(bank_sel),
    .return_stack_top(stack_top), .pc_high_latch(pc_hi), .pc_upper_latch(pc_up),
    .working_register(work_out), .indirect_pointer_reg(ptr), .nz_flags(nz),
    .pc_load(pc_load), .pc_target(pc_target), .stack_push(stack_push),
    .stack_push_data(push_data), .stack_pop(stack_pop), .second_cycle(second_cycle),
    .illegal_ext(illegal_ext)
  );

  // ----
  // pulse recorder, sampled mid-cycle
  // ----
  always @(negedge clock) begin
    n_neg++;
    if (second_cycle === 1'b1) n_sc++;
    if (stack_pop === 1'b1) n_pop++;
    if (illegal_ext === 1'b1) n_ill++;
    if (pc_load === 1'b1) begin
      n_ld++;
      s_pt = pc_target;
    end
    if (stack_push === 1'b1) begin
      n_push++;
      s_pd = push_data;
    end
    if (rf_we === 1'b1) begin
      n_we++;
      s_ph = n_neg;
      s_wa = rf_waddr;
      s_wd = rf_wdata;
      mem[rf_waddr] = rf_wdata;
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic rnd();
    vb = 4'($urandom);
    vt = 21'($urandom);
    vh = 8'($urandom);
    vu = 5'($urandom);
    vpc = 21'($urandom);
  endtask : rnd

  // one instruction cycle per word, starting at q1
  task automatic op(input logic [15:0] w1, input logic [15:0] w2, input logic two);
    n_we = 0;
    n_ld = 0;
    n_push = 0;
    n_pop = 0;
    n_ill = 0;
    n_sc = 0;
    n_neg = 0;
    insn <= w1;
    pc_in <= vpc;
    bank_sel <= vb;
    stack_top <= vt;
    pc_hi <= vh;
    pc_up <= vu;
    repeat (4) @(posedge clock);
    if (two) begin
      insn <= w2;
      repeat (4) @(posedge clock);
    end
    #1;
  endtask : op

  task automatic post(input int we, input int ld, input int pu, input int po, input int il,
                      input int tw);
    chk(n_we, we);
    chk(n_ld, ld);
    chk(n_push, pu);
    chk(n_pop, po);
    chk(n_ill, il);
    chk(n_sc, 4 * tw);
    foreach (mp[i]) chk(ptr[i], mp[i]);
    chk(work_out, mw);
    chk(nz, mf);
  endtask : post

  function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
    if (!a && ext_en && f <= 8'h5F) return mp[2] + 12'(f);
    if (a) return {vb, f};
    return (f < 8'h80) ? {4'h0, f} : {4'hF, f};
  endfunction : ea

  task automatic t_xor(input logic d, input logic a, input logic [7:0] f);
    logic [11:0] ad;
    logic [7:0] r;
    rnd();
    ad = ea(a, f);
    r = mw ^ mem[ad];
    op({6'h06, d, a, f}, 16'h0000, 1'b0);
    if (!d) mw = r;
    mf = {r[7], r == 8'h00};
    post(d, 0, 0, 0, 0, 0);
    if (d) begin
      chk(s_wa, ad);
      chk(s_wd, r);
      chk(s_ph, 4);
    end
  endtask : t_xor

  task automatic t_ptr(input logic sub, input logic [1:0] s, input logic [5:0] k);
    int i;
    logic r;
    i = (s == 2'h3) ? 2 : int'(s);
    r = ext_en && s == 2'h3;
    rnd();
    op({7'h74, sub, s, k}, 16'h0000, r);
    if (ext_en) mp[i] = sub ? mp[i] - 12'(k) : mp[i] + 12'(k);
    post(0, r, 0, r, !ext_en, r);
    if (r) chk(s_pt, vt);
  endtask : t_ptr

  task automatic t_push(input logic [7:0] k);
    logic e;
    logic [11:0] a;
    e = ext_en;
    a = mp[2];
    rnd();
    op({8'hEA, k}, 16'h0000, 1'b0);
    if (e) mp[2] = a - 12'h001;
    post(e, 0, 0, 0, !e, 0);
    if (e) begin
      chk(s_wa, a);
      chk(s_wd, k);
    end
  endtask : t_push

  task automatic t_mov(input logic kind);
    logic e;
    logic [6:0] z, z2;
    logic [11:0] s, d;
    logic [7:0] v;
    e = ext_en;
    z = 7'($urandom);
    z2 = 7'($urandom);
    d = 12'($urandom);
    rnd();
    s = mp[2] + 12'(z);
    if (kind) d = mp[2] + 12'(z2);
    v = mem[s];
    op({8'hEB, kind, z}, kind ? {4'hF, 5'($urandom), z2} : {4'hF, d}, e);
    post(e, 0, 0, 0, !e, e);
    if (e) begin
      chk(s_wa, d);
      chk(s_wd, v);
    end
  endtask : t_mov

  task automatic t_call();
    logic e;
    e = ext_en;
    rnd();
    op(16'h0014, 16'h0000, e);
    post(0, e, e, 0, 0, e);
    if (e) begin
      chk(s_pt, {vu, vh, mw});
      chk(s_pd, vpc + 21'h000002);
    end
  endtask : t_call

  task automatic mix(input int n);
    repeat (n) begin
      case ($urandom_range(4))
        0: t_xor(1'($urandom), 1'($urandom), 8'($urandom));
        1: t_ptr(1'($urandom), 2'($urandom), 6'($urandom));
        2: t_push(8'($urandom));
        3: t_mov(1'($urandom));
        default: t_call();
      endcase
    end
  endtask : mix

  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32));
    foreach (mem[i]) mem[i] = 8'($urandom);
    mem[0] = 8'h80;
    repeat (10) @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    // xor into 000h with working reg zero leaves data intact and shows where q4 is
    insn <= 16'h1B00;
    repeat (12) begin
      @(negedge clock);
      if (rf_we === 1'b1) break;
    end
    chk(rf_we, 1'b1);
    @(posedge clock);
    #1;
    mf = 2'h2;
    t_xor(1'b1, 1'b0, 8'h5F);
    t_xor(1'b0, 1'b0, 8'h80);
    t_xor(1'b1, 1'b1, 8'h10);
    mix(30);
    ext_en <= 1'b1;
    t_xor(1'b1, 1'b1, 8'h22);
    t_xor(1'b1, 1'b1, 8'h33);
    t_xor(1'b1, 1'b0, 8'h5F);
    t_xor(1'b0, 1'b0, 8'h60);
    t_ptr(1'b0, 2'h3, 6'h3F);
    t_ptr(1'b1, 2'h3, 6'h3F);
    t_ptr(1'b0, 2'h2, 6'h3F);
    t_ptr(1'b1, 2'h0, 6'h00);
    t_push(8'hFF);
    t_mov(1'b0);
    t_mov(1'b1);
    t_call();
    t_call();
    mix(90);
    tally_and_finish();
  end
endmodule : xd_ext_decoder_bench

// *** rtl/xd_addr_mode.sv ***
// module: file address mode select for byte-oriented instructions
`timescale 1ns/10ps
module xd_addr_mode (
  // controls
  input wire logic ext_en,
  input wire logic access_sel,
  input wire logic [7:0] faddr,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] frame_ptr,
  // result
  output logic [11:0] eff_addr,
  output logic indexed
);
  always_comb begin
    indexed = ext_en && !access_sel && (faddr <= xd_pkg::IDX_LIMIT);
    if (indexed) begin
      eff_addr = frame_ptr + {4'h0, faddr};
    end else if (access_sel) begin
      eff_addr = {bank_select_register, faddr};
    end else begin
      eff_addr = {faddr[7] ? 4'hF : 4'h0, faddr};
    end
  end
endmodule : xd_addr_mode

// *** rtl/xd_ext_decoder.sv ***
// module: register-xor and extended instruction decode and execute
// What this block does
// - xor working register with file register; destination bit picks working or file
// - xor updates only negative and zero flags; one word, one cycle
// - access bit 0 picks access bank, 1 uses bank select register
// - extension on, access 0, address up to 95: indexed literal offset
// - extension off by default; enabled only by the enable configuration bit
// - eight extra instructions when enabled; none touches any status flag
// - pointer add and subtract: one cycle, two-bit select, six-bit literal
// - select 11: apply literal to frame pointer then return, two cycles
// - opcode 0014h is a two-cycle call with target low byte from working register
// - indexed-to-absolute move: two words, two cycles, twelve-bit destination
// - indexed-to-indexed move: two words, seven-bit destination offset, don't-cares ignored
// - literal push stores at frame pointer then decrements it, one cycle
// - only the return variants and the call via working register change program flow
// - literal is six-bit unsigned; select 0 to 2 names the pointers
// - return variant loads pc from stack top, second cycle is a no-op
// - call pushes pc plus 2, loads low from working, high and upper from latches
// - indexed source address is seven-bit offset plus frame pointer
`timescale 1ns/10ps
module xd_ext_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration
  input wire logic extended_set_enable_bit,
  // instruction fetch
  input wire logic [15:0] insn,
  input wire logic [20:0] pc_in,
  // register file
  output logic [11:0] rf_addr,
  output logic rf_rd,
  input wire logic [7:0] rf_rdata,
  output logic rf_we,
  output logic [11:0] rf_waddr,
  output logic [7:0] rf_wdata,
  // core state inputs
  input wire logic [3:0] bank_select_register,
  input wire logic [20:0] return_stack_top,
  input wire logic [7:0] pc_high_latch,
  input wire logic [4:0] pc_upper_latch,
  // core state outputs
  output logic [7:0] working_register,
  output logic [11:0] indirect_pointer_reg [3],
  output logic [1:0] nz_flags,
  output logic pc_load,
  output logic [20:0] pc_target,
  output logic stack_push,
  output logic [20:0] stack_push_data,
  output logic stack_pop,
  output logic second_cycle,
  output logic illegal_ext
);
  // ---------------------------------------------------------------
  // phase timing and configuration capture
  // ---------------------------------------------------------------
  xd_phase_if ph ();
  xd_phase_gen u_ph (
    .clock(clock),
    .rst_n(rst_n),
    .ph(ph.gen)
  );
  logic ext_en_s1_q;
  logic ext_en_q;
  // extension defaults to off until the config bit has passed the synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_en_s1_q <= 1'b0;
      ext_en_q <= 1'b0;
    end else begin
      ext_en_s1_q <= extended_set_enable_bit;
      ext_en_q <= ext_en_s1_q;
    end
  end
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    XD_NONE, XD_XOR, XD_PADD, XD_PSUB, XD_PUSH, XD_MOVE, XD_CALL_VIA_WORKING_REG
  } xd_op_t;
  typedef enum {S_FIRST, S_SECOND} xd_state_t;
  xd_state_t st_q, st_d;
  xd_op_t op;
  logic [15:0] ir_q, ir_d;
  logic [11:0] src_q, src_d;
  logic [7:0] tmp_q, tmp_d;
  logic ret_q, ret_d;
  always_comb begin
    op = XD_NONE;
    if (insn[15:10] == xd_pkg::OPC_XOR_FILE_HI) begin
      op = XD_XOR;
    end else if (ext_en_q) begin
      if (insn[15:8] == xd_pkg::OPC_PTR_ADD) begin
        op = XD_PADD;
      end else if (insn[15:8] == xd_pkg::OPC_PTR_SUB) begin
        op = XD_PSUB;
      end else if (insn[15:8] == xd_pkg::OPC_PUSH_LIT) begin
        op = XD_PUSH;
      end else if (insn[15:8] == xd_pkg::OPC_MOVE_IDX) begin
        op = XD_MOVE;
      end else if (insn == xd_pkg::OPC_CALL_W) begin
        op = XD_CALL_VIA_WORKING_REG;
      end
    end
  end
  logic [11:0] xor_addr;
  logic xor_indexed;
  xd_addr_mode u_am (
    .ext_en(ext_en_q),
    .access_sel(insn[xd_pkg::POS_ACCESS]),
    .faddr(insn[7:0]),
    .bank_select_register(bank_select_register),
    .frame_ptr(indirect_pointer_reg[xd_pkg::FRAME_PTR_IDX]),
    .eff_addr(xor_addr),
    .indexed(xor_indexed)
  );
  // ---------------------------------------------------------------
  // execute
  // ---------------------------------------------------------------
  logic [7:0] wk_q, wk_d;
  logic [11:0] ptr_q [3];
  logic [11:0] ptr_d [3];
  logic [1:0] nz_q, nz_d;
  logic [7:0] xres;
  logic [1:0] psel;
  logic [11:0] lit6;
  always_comb begin
    st_d = st_q;
    ir_d = ir_q;
    src_d = src_q;
    tmp_d = tmp_q;
    ret_d = ret_q;
    wk_d = wk_q;
    ptr_d = ptr_q;
    nz_d = nz_q;
    xres = wk_q ^ rf_rdata;
    psel = insn[7:6];
    lit6 = {6'h00, insn[5:0]};
    rf_addr = 12'h000;
    rf_rd = 1'b0;
    rf_we = 1'b0;
    rf_waddr = 12'h000;
    rf_wdata = 8'h00;
    pc_load = 1'b0;
    pc_target = xd_pkg::RST_PC;
    stack_push = 1'b0;
    stack_push_data = xd_pkg::RST_PC;
    stack_pop = 1'b0;
    illegal_ext = 1'b0;
    unique case (st_q)
      S_FIRST: begin
        if (op == XD_XOR) begin
          rf_addr = xor_addr;
          rf_rd = (ph.phase == 2'h1) || (ph.phase == 2'h2);
          if (ph.q4) begin
            if (insn[xd_pkg::POS_DEST]) begin
              rf_we = 1'b1;
              rf_waddr = xor_addr;
              rf_wdata = tmp_q;
            end else begin
              wk_d = tmp_q;
            end
            nz_d = {tmp_q[7], tmp_q == 8'h00};
          end
          if (ph.phase == 2'h2) begin
            tmp_d = xres;
          end
        end else if (ph.q4) begin
          unique case (op)
            XD_PADD, XD_PSUB: begin
              if (psel == xd_pkg::PSEL_FRAME_RET) begin
                ptr_d[xd_pkg::FRAME_PTR_IDX] = (op == XD_PADD) ?
                  ptr_q[xd_pkg::FRAME_PTR_IDX] + lit6 :
                  ptr_q[xd_pkg::FRAME_PTR_IDX] - lit6;
                pc_load = 1'b1;
                pc_target = return_stack_top;
                stack_pop = 1'b1;
                ret_d = 1'b1;
                st_d = S_SECOND;
              end else begin
                // no pc action here: flow is untouched
                ptr_d[psel] = (op == XD_PADD) ? ptr_q[psel] + lit6 :
                  ptr_q[psel] - lit6;
              end
            end
            XD_PUSH: begin
              rf_we = 1'b1;
              rf_waddr = ptr_q[xd_pkg::FRAME_PTR_IDX];
              rf_wdata = insn[7:0];
              ptr_d[xd_pkg::FRAME_PTR_IDX] = ptr_q[xd_pkg::FRAME_PTR_IDX] - 12'h001;
            end
            XD_MOVE: begin
              src_d = ptr_q[xd_pkg::FRAME_PTR_IDX] + {5'h00, insn[6:0]};
              ir_d = insn;
              st_d = S_SECOND;
            end
            XD_CALL_VIA_WORKING_REG: begin
              stack_push = 1'b1;
              stack_push_data = pc_in + xd_pkg::PC_STEP;
              pc_load = 1'b1;
              pc_target = {pc_upper_latch, pc_high_latch, wk_q};
              ret_d = 1'b0;
              st_d = S_SECOND;
            end
            default: begin
              illegal_ext = (insn[15:12] == 4'hE) && !ext_en_q;
            end
          endcase
        end
      end
      S_SECOND: begin
        if (ir_q[15:8] == xd_pkg::OPC_MOVE_IDX) begin
          rf_addr = src_q;
          rf_rd = (ph.phase == 2'h2) || (ph.phase == 2'h3);
          if (ph.phase == 2'h2) begin
            tmp_d = rf_rdata;
          end
          if (ph.q4) begin
            rf_we = (insn[15:12] == xd_pkg::OPC_SECOND_WORD);
            rf_waddr = ir_q[xd_pkg::POS_MOVE_KIND] ?
              ptr_q[xd_pkg::FRAME_PTR_IDX] + {5'h00, insn[6:0]} :
              insn[11:0];
            rf_wdata = tmp_q;
          end
        end
        if (ph.q4) begin
          ir_d = 16'h0000;
          st_d = S_FIRST;
        end
      end
    endcase
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_FIRST;
      ir_q <= 16'h0000;
      src_q <= xd_pkg::RST_PTR;
      tmp_q <= 8'h00;
      ret_q <= 1'b0;
      wk_q <= xd_pkg::RST_WORK_REG;
      ptr_q <= '{default: xd_pkg::RST_PTR};
      nz_q <= xd_pkg::RST_FLAGS;
    end else begin
      st_q <= st_d;
      ir_q <= ir_d;
      src_q <= src_d;
      tmp_q <= tmp_d;
      ret_q <= ret_d;
      wk_q <= wk_d;
      ptr_q <= ptr_d;
      nz_q <= nz_d;
    end
  end
  assign working_register = wk_q;
  assign indirect_pointer_reg = ptr_q;
  assign nz_flags = nz_q;
  assign second_cycle = (st_q == S_SECOND);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_ret_start;
    ph.q4 && (st_q == S_FIRST) && (op inside {XD_PADD, XD_PSUB}) && psel == 2'h3;
  endsequence
  AST_XOR_W: assert property (ph.q4 && st_q == S_FIRST && op == XD_XOR && !insn[9]
    |=> wk_q == $past(tmp_q)) else $error("xor result not in working reg");
  AST_XOR_FLAGS: assert property (ph.q4 && st_q == S_FIRST && op == XD_XOR
    |=> nz_q == {$past(tmp_q[7]), $past(tmp_q) == 8'h00})
    else $error("zero flag wrong");
  AST_EXT_FLAGS: assert property (op != XD_XOR |=> $stable(nz_q))
    else $error("flags changed by non-xor");
  AST_EXT_OFF: assert property (!ext_en_q |-> op inside {XD_NONE, XD_XOR})
    else $error("extended op while disabled");
  AST_IDX_MODE: assert property (xor_indexed |-> ext_en_q && !insn[8] && insn[7:0] <= 8'h5F)
    else $error("indexed mode wrongly chosen");
  AST_RET_TWO: assert property (s_ret_start |-> pc_load ##1 second_cycle[*4] ##1 !second_cycle)
    else $error("return variant not two cycles");
  AST_PLAIN_NOFLOW: assert property (ph.q4 && st_q == S_FIRST && op == XD_PADD && psel != 2'h3
    |-> !pc_load && !stack_pop) else $error("plain pointer add touched flow");
  AST_PUSH: assert property (ph.q4 && st_q == S_FIRST && op == XD_PUSH
    |-> rf_we ##1 ptr_q[2] == $past(ptr_q[2]) - 12'h001) else $error("push wrong");
  AST_CALL_VIA_WORKING_REG: assert property (ph.q4 && st_q == S_FIRST && op == XD_CALL_VIA_WORKING_REG
    |-> stack_push && stack_push_data == pc_in + 21'h000002 && pc_target[7:0] == wk_q)
    else $error("call via working reg wrong");
  AST_RESET_OFF: assert property ($rose(rst_n) |-> !ext_en_q)
    else $error("extension on at reset");
endmodule : xd_ext_decoder

// *** rtl/xd_phase_gen.sv ***
// module: four-phase instruction cycle sequencer
`timescale 1ns/10ps
module xd_phase_gen (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // phase out
  xd_phase_if.gen ph
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q + 2'h1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign ph.phase = cnt_q;
  assign ph.q4 = (cnt_q == 2'h3);
endmodule : xd_phase_gen

// *** rtl/xd_phase_if.sv ***
// interface: phase timing shared between sequencer and core
`timescale 1ns/10ps
interface xd_phase_if;
  logic [1:0] phase;
  logic q4;
  modport gen (output phase, output q4);
  modport use_ph (input phase, input q4);
endinterface : xd_phase_if

// *** rtl/xd_pkg.sv ***
// package: opcodes, field positions, widths and constants of the extended decoder
package xd_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned INSN_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PC_W = 21;
  localparam int unsigned NPTR = 3;
  // ---------------------------------------------------------------
  // opcode patterns
  // ---------------------------------------------------------------
  localparam logic [5:0] OPC_XOR_FILE_HI = 6'h06;
  localparam logic [7:0] OPC_PTR_ADD = 8'hE8;
  localparam logic [7:0] OPC_PTR_SUB = 8'hE9;
  localparam logic [7:0] OPC_PUSH_LIT = 8'hEA;
  localparam logic [7:0] OPC_MOVE_IDX = 8'hEB;
  localparam logic [15:0] OPC_CALL_W = 16'h0014;
  localparam logic [3:0] OPC_SECOND_WORD = 4'hF;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned POS_DEST = 9;
  localparam int unsigned POS_ACCESS = 8;
  localparam int unsigned POS_PSEL = 6;
  localparam int unsigned POS_MOVE_KIND = 7;
  localparam logic [1:0] PSEL_FRAME_RET = 2'h3;
  localparam logic [1:0] FRAME_PTR_IDX = 2'h2;
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_WORK_REG = 8'h00;
  localparam logic [ADDR_W-1:0] RST_PTR = 12'h000;
  localparam logic [PC_W-1:0] RST_PC = 21'h000000;
  localparam logic [1:0] RST_FLAGS = 2'h0;
  // ---------------------------------------------------------------
  // quadrature phases
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} xd_phase_t;
endpackage : xd_pkg
